// ---- bhp_pkg.sv ----
// ============================================================
// Operation
// - static whether hint allocates direction entry only for static-taken call/return
// - dynamic hint allocates after first mispredict
// - no entry: hint decides; taken hint fills cache
// - no_allocate hint allocates nothing, updates no table; return stack still moves
// - many hint, taken, third slot: stream from next line
// - first taken branch, not return or static not-taken, allocates target cache entry
// - static-taken call/return allocates, always predicted taken; a target register hit at loop end wins and predicts not taken
// - predict hint fills target cache, not direction
// - importance hint also allocates target register
// - move-to-branch taken hints fill target cache
// - indirect predict hint forms do nothing
// - bundle type selects large or multiway table
// - target register hit taken unless loop ends
// - direction table hit gives direction
// - target hit without direction entry: taken
// - no hit anywhere: follow whether hint
// - 64 cache, 4 registers, 8 stack entries
// - return, register, cache, corrector, else mispredict
// - mispredict costs nine bubble cycles
// - register hit zero bubbles, cache hit one
// - first corrector two bubbles, second three
// - return bubbles one from table, two from hint
// - taken calls and returns always move return stack
// - predict hint acts only in third slot
package bhp_pkg;
    localparam int AW     = 32;
    localparam int TAC_N  = 64;
    localparam int TAR_N  = 4;
    localparam int RS_N   = 8;
    localparam int DT_N   = 128;
    localparam int MDT_N  = 16;
    localparam int TAC_IW = 6;
    localparam int DT_IW  = 7;
    localparam int MDT_IW = 4;
    localparam int TAR_IW = 2;
    localparam int RS_IW  = 3;
    localparam logic [3:0] MISS_BUBBLES = 4'h9;
    localparam logic [3:0] TAC_BUBBLES  = 4'h1;
    localparam logic [3:0] AC1_BUBBLES  = 4'h2;
    localparam logic [3:0] AC2_BUBBLES  = 4'h3;
    localparam logic [3:0] RET_DIR_BUB  = 4'h1;
    localparam logic [3:0] RET_HINT_BUB = 4'h2;
    localparam logic [1:0] BRP_SLOT     = 2'h2;
    localparam logic [5:0] LOOP_END_EC  = 6'h01;
    localparam int L2_SHIFT = 3;
    localparam logic [AW-1:0] NEXT_BUNDLE = 32'h0000_0001;
    localparam logic [1:0] CTR_TK_INIT = 2'h2;
    localparam logic [1:0] CTR_NT_INIT = 2'h1;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MISS_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;
    localparam int CTRL_PF_BIT    = 0;
    localparam int CTRL_ALLOC_BIT = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        W_NONE = 3'h0, W_SPTK = 3'h1, W_SPNT = 3'h2, W_DPTK = 3'h3,
        W_DPNT = 3'h4, W_LOOP = 3'h5, W_EXIT = 3'h6
    } bhp_whether_type;

    typedef enum logic [2:0] {
        B_MEM_INT = 3'h0, B_MEM_FLT = 3'h1, B_MEM_MEM = 3'h2,
        B_MEM_TWO = 3'h3, B_THREE = 3'h4, B_OTHER = 3'h7
    } bhp_bundle_type;

    typedef struct packed {
        logic [AW-1:0]   addr;
        bhp_bundle_type  btype;
        logic [1:0]      slot;
        logic            is_call;
        logic            is_ret;
        logic            ip_rel;
        logic [AW-1:0]   disp;
        bhp_whether_type whether;
        logic            many;
        logic            clr;
    } bhp_lookup_type;

    typedef struct packed {
        logic [AW-1:0]   addr;
        bhp_bundle_type  btype;
        logic [1:0]      slot;
        logic            is_call;
        logic            is_ret;
        bhp_whether_type whether;
        logic            clr;
        logic            taken;
        logic            mispred;
        logic [AW-1:0]   target;
    } bhp_resolve_type;

    typedef struct packed {
        logic            is_mov;
        logic [AW-1:0]   addr;
        logic [AW-1:0]   target;
        logic [1:0]      slot;
        bhp_whether_type whether;
        logic            imp;
        logic            indirect;
    } bhp_hint_type;

    typedef struct packed {
        logic          valid;
        logic          taken;
        logic          known;
        logic [AW-1:0] target;
        logic [3:0]    bubbles;
    } bhp_pred_type;
endpackage

// ---- bhp_predictor.sv ----
`timescale 1ns/1ps
module bhp_predictor (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     lk_valid,
    input  wire bhp_pkg::bhp_lookup_type  lk,
    input  wire logic [63:0]              loop_count,
    input  wire logic [5:0]               epilog_count,
    input  wire logic                     rs_valid,
    input  wire bhp_pkg::bhp_resolve_type rs,
    input  wire logic                     hi_valid,
    input  wire bhp_pkg::bhp_hint_type    hi,
    output bhp_pkg::bhp_pred_type         pred,
    output logic                          pf_start,
    output logic [bhp_pkg::AW-1:0]        pf_line,
    output logic                          stall,
    input  wire logic [7:0]               awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    input  wire logic [7:0]               araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready
);
    localparam int AW = bhp_pkg::AW;

    function automatic logic is_mway(input bhp_pkg::bhp_bundle_type b);
        is_mway = (b == bhp_pkg::B_MEM_TWO) || (b == bhp_pkg::B_THREE);
    endfunction

    function automatic logic is_static(input bhp_pkg::bhp_whether_type w);
        is_static = (w == bhp_pkg::W_SPTK) || (w == bhp_pkg::W_SPNT);
    endfunction

    function automatic logic hint_tk(input bhp_pkg::bhp_whether_type w);
        hint_tk = (w == bhp_pkg::W_SPTK) || (w == bhp_pkg::W_DPTK);
    endfunction

    // ========================================================
    // storage
    logic          dt_v   [bhp_pkg::DT_N];
    logic [AW-1:0] dt_tag [bhp_pkg::DT_N];
    logic [1:0]    dt_ctr [bhp_pkg::DT_N];
    logic          mdt_v  [bhp_pkg::MDT_N];
    logic [AW-1:0] mdt_tag[bhp_pkg::MDT_N];
    logic [1:0]    mdt_ctr[bhp_pkg::MDT_N];
    logic          tac_v  [bhp_pkg::TAC_N];
    logic [AW-1:0] tac_tag[bhp_pkg::TAC_N];
    logic [AW-1:0] tac_tgt[bhp_pkg::TAC_N];
    logic [1:0]    tac_slot[bhp_pkg::TAC_N];
    logic          tar_v  [bhp_pkg::TAR_N];
    logic [AW-2:0] tar_tag[bhp_pkg::TAR_N];
    logic [AW-1:0] tar_tgt[bhp_pkg::TAR_N];
    logic [AW-1:0] rs_mem [bhp_pkg::RS_N];
    logic [bhp_pkg::TAR_IW-1:0] tar_ptr;
    logic [bhp_pkg::RS_IW-1:0]  rs_ptr;
    logic [31:0]   ctrl;
    logic [15:0]   miss_cnt;
    logic [3:0]    bub_cnt;
    logic          ac1_busy;

    // ========================================================
    // lookup
    logic          l_mw, l_dhit, l_dtk, l_tachit, l_tarhit, l_lend;
    logic          l_tk, l_known, l_ac1, l_pf;
    logic [AW-1:0] l_tgt, l_tartgt;
    logic [3:0]    l_bub;
    logic [bhp_pkg::DT_IW-1:0]  l_di;
    logic [bhp_pkg::MDT_IW-1:0] l_mi;
    logic [bhp_pkg::TAC_IW-1:0] l_ti;

    assign l_di = lk.addr[bhp_pkg::DT_IW-1:0];
    assign l_mi = lk.addr[bhp_pkg::MDT_IW-1:0];
    assign l_ti = lk.addr[bhp_pkg::TAC_IW-1:0];

    always_comb begin
        l_mw = is_mway(lk.btype);
        l_dhit = l_mw ? (mdt_v[l_mi] && mdt_tag[l_mi] == lk.addr)
                      : (dt_v[l_di] && dt_tag[l_di] == lk.addr);
        l_dtk = l_mw ? mdt_ctr[l_mi][1] : dt_ctr[l_di][1];
        l_tachit = tac_v[l_ti] && tac_tag[l_ti] == lk.addr;
        l_tarhit = 1'b0;
        l_tartgt = '0;
        for (int i = 0; i < bhp_pkg::TAR_N; i++) begin
            if (tar_v[i] && tar_tag[i] == lk.addr[AW-1:1]) begin
                l_tarhit = 1'b1;
                l_tartgt = tar_tgt[i];
            end
        end
        l_lend = l_tarhit && loop_count == 64'h0
                 && epilog_count == bhp_pkg::LOOP_END_EC;
        if (l_tarhit) begin
            l_tk = !l_lend;
        end else if ((lk.is_call || lk.is_ret)
                     && lk.whether == bhp_pkg::W_SPTK) begin
            l_tk = 1'b1;
        end else if (l_dhit) begin
            l_tk = l_dtk;
        end else if (l_tachit) begin
            l_tk = 1'b1;
        end else begin
            l_tk = hint_tk(lk.whether);
        end
        l_known = 1'b1;
        l_ac1 = 1'b0;
        if (lk.is_ret) begin
            l_tgt = rs_mem[rs_ptr];
            l_bub = l_dhit ? bhp_pkg::RET_DIR_BUB
                           : bhp_pkg::RET_HINT_BUB;
        end else if (l_tarhit) begin
            l_tgt = l_tartgt;
            l_bub = 4'h0;
        end else if (l_tachit) begin
            l_tgt = tac_tgt[l_ti];
            l_bub = bhp_pkg::TAC_BUBBLES;
        end else if (lk.ip_rel) begin
            l_tgt = lk.addr + lk.disp;
            // one corrector per cycle; a back-to-back branch takes the slower
            l_ac1 = !ac1_busy;
            l_bub = ac1_busy ? bhp_pkg::AC2_BUBBLES
                             : bhp_pkg::AC1_BUBBLES;
        end else begin
            l_tgt = lk.addr + bhp_pkg::NEXT_BUNDLE;
            l_known = 1'b0;
            l_bub = 4'h0;
        end
        if (!l_tk) begin
            l_bub = 4'h0;
        end
        l_pf = lk_valid && l_tk && lk.many && lk.slot == bhp_pkg::BRP_SLOT
               && ctrl[bhp_pkg::CTRL_PF_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pred <= '0;
            ac1_busy <= 1'b0;
        end else begin
            pred.valid <= lk_valid;
            pred.taken <= lk_valid && l_tk;
            pred.known <= l_known;
            pred.target <= l_tgt;
            pred.bubbles <= lk_valid ? l_bub : 4'h0;
            ac1_busy <= lk_valid && l_tk && l_ac1;
        end
    end

    // ========================================================
    // streaming prefetch
    localparam logic [AW-1:0] NEXT_ONE = bhp_pkg::NEXT_BUNDLE;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pf_start <= 1'b0;
            pf_line <= '0;
        end else begin
            pf_start <= l_pf;
            pf_line <= AW'(((l_tgt >> bhp_pkg::L2_SHIFT) + NEXT_ONE)
                           << bhp_pkg::L2_SHIFT);
        end
    end
    // ========================================================
    // update from execute and hints
    logic alloc_ok, r_mw, r_dhit, r_dnew, r_dupd, r_tac;
    logic h_act, h_tac, h_tar;
    logic [bhp_pkg::DT_IW-1:0]  r_di;
    logic [bhp_pkg::MDT_IW-1:0] r_mi;
    logic [bhp_pkg::TAC_IW-1:0] r_ti, h_ti;
    logic [1:0] r_ctr;

    assign r_di = rs.addr[bhp_pkg::DT_IW-1:0];
    assign r_mi = rs.addr[bhp_pkg::MDT_IW-1:0];
    assign r_ti = rs.addr[bhp_pkg::TAC_IW-1:0];
    assign h_ti = hi.addr[bhp_pkg::TAC_IW-1:0];

    always_comb begin
        alloc_ok = rs_valid && !rs.clr
                   && ctrl[bhp_pkg::CTRL_ALLOC_BIT];
        r_mw = is_mway(rs.btype);
        r_dhit = r_mw ? (mdt_v[r_mi] && mdt_tag[r_mi] == rs.addr)
                      : (dt_v[r_di] && dt_tag[r_di] == rs.addr);
        r_ctr = r_mw ? mdt_ctr[r_mi] : dt_ctr[r_di];
        if (is_static(rs.whether)) begin
            r_dnew = (rs.is_call || rs.is_ret)
                     && rs.whether == bhp_pkg::W_SPTK;
        end else begin
            r_dnew = rs.mispred
                     || ((rs.is_call || rs.is_ret) && rs.taken);
        end
        r_dnew = r_dnew && alloc_ok && !r_dhit;
        r_dupd = alloc_ok && r_dhit;
        if (r_ctr != 2'h3 && rs.taken) begin
            r_ctr = r_ctr + 2'h1;
        end else if (r_ctr != 2'h0 && !rs.taken) begin
            r_ctr = r_ctr - 2'h1;
        end
        r_tac = alloc_ok && rs.taken && rs.whether != bhp_pkg::W_SPNT
                && !rs.is_ret;
        h_act = hi_valid && !hi.indirect && ctrl[bhp_pkg::CTRL_ALLOC_BIT]
                && (hi.is_mov || hi.slot == bhp_pkg::BRP_SLOT);
        h_tac = h_act && (hint_tk(hi.whether)
                || (!hi.is_mov && hi.whether == bhp_pkg::W_LOOP));
        h_tar = h_tac && hi.imp;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < bhp_pkg::DT_N; i++) dt_v[i] <= 1'b0;
            for (int i = 0; i < bhp_pkg::MDT_N; i++) mdt_v[i] <= 1'b0;
        end else if (r_dnew || r_dupd) begin
            if (r_mw) begin
                mdt_v[r_mi] <= 1'b1;
                mdt_tag[r_mi] <= rs.addr;
                mdt_ctr[r_mi] <= r_dnew ? (rs.taken ? bhp_pkg::CTR_TK_INIT
                                 : bhp_pkg::CTR_NT_INIT) : r_ctr;
            end else begin
                dt_v[r_di] <= 1'b1;
                dt_tag[r_di] <= rs.addr;
                dt_ctr[r_di] <= r_dnew ? (rs.taken ? bhp_pkg::CTR_TK_INIT
                                : bhp_pkg::CTR_NT_INIT) : r_ctr;
            end
        end
    end

    // a hint losing the port to a resolving branch is dropped from the cache; its target register write still happens
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < bhp_pkg::TAC_N; i++) tac_v[i] <= 1'b0;
        end else if (r_tac) begin
            tac_v[r_ti] <= 1'b1;
            tac_tag[r_ti] <= rs.addr;
            tac_tgt[r_ti] <= rs.target;
            tac_slot[r_ti] <= rs.slot;
        end else if (h_tac) begin
            tac_v[h_ti] <= 1'b1;
            tac_tag[h_ti] <= hi.addr;
            tac_tgt[h_ti] <= hi.target;
            tac_slot[h_ti] <= bhp_pkg::BRP_SLOT;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < bhp_pkg::TAR_N; i++) tar_v[i] <= 1'b0;
            tar_ptr <= '0;
        end else if (h_tar) begin
            tar_v[tar_ptr] <= 1'b1;
            tar_tag[tar_ptr] <= hi.addr[AW-1:1];
            tar_tgt[tar_ptr] <= hi.target;
            tar_ptr <= tar_ptr + 2'h1;
        end
    end

    // circular stack: overflow silently loses the oldest return
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rs_ptr <= '0;
        end else if (rs_valid && rs.is_call && rs.taken) begin
            rs_mem[rs_ptr + 3'h1] <= rs.addr + bhp_pkg::NEXT_BUNDLE;
            rs_ptr <= rs_ptr + 3'h1;
        end else if (rs_valid && rs.is_ret && rs.taken) begin
            rs_ptr <= rs_ptr - 3'h1;
        end
    end

    // ========================================================
    // mispredict bubbles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bub_cnt <= 4'h0;
            stall <= 1'b0;
        end else begin
            if (rs_valid && rs.mispred) begin
                bub_cnt <= bhp_pkg::MISS_BUBBLES;
            end else if (bub_cnt != 4'h0) begin
                bub_cnt <= bub_cnt - 4'h1;
            end
            stall <= (rs_valid && rs.mispred) || bub_cnt > 4'h1;
        end
    end

    // ========================================================
    // register bus
    logic       wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign wr_fire = !awready && !wready && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= bhp_pkg::RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= (wr_addr == bhp_pkg::CTRL_OFS
                          || wr_addr == bhp_pkg::MISS_OFS
                          || wr_addr == bhp_pkg::STAT_OFS)
                         ? bhp_pkg::RESP_OKAY : bhp_pkg::RESP_DECERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= bhp_pkg::CTRL_RST;
        end else if (wr_fire && wr_addr == bhp_pkg::CTRL_OFS
                     && wr_strb[0]) begin
            ctrl <= {30'h0, wr_data[1:0]};
        end
    end

    // writing the counter clears it; a same-cycle miss still counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            miss_cnt <= 16'h0000;
        end else if (wr_fire && wr_addr == bhp_pkg::MISS_OFS) begin
            miss_cnt <= {15'h0000, rs_valid && rs.mispred};
        end else if (rs_valid && rs.mispred && miss_cnt != 16'hFFFF) begin
            miss_cnt <= miss_cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= bhp_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= bhp_pkg::RESP_OKAY;
            case (araddr)
                bhp_pkg::CTRL_OFS: rdata <= ctrl;
                bhp_pkg::MISS_OFS: rdata <= {16'h0000, miss_cnt};
                bhp_pkg::STAT_OFS: rdata <= {23'h000000, rs_ptr,
                                             bub_cnt, stall, 1'b0};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= bhp_pkg::RESP_DECERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // cycles since the last mispredict; parks at 15 so it never wraps
    logic [3:0] miss_age;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            miss_age <= 4'h0;
        end else if (rs_valid && rs.mispred) begin
            miss_age <= 4'h1;
        end else if (miss_age != 4'h0 && miss_age != 4'hF) begin
            miss_age <= miss_age + 4'h1;
        end
    end
    property p_miss_stall;
        miss_age != 4'h0
        |-> stall == (miss_age <= bhp_pkg::MISS_BUBBLES);
    endproperty
    a_miss_stall: assert property (p_miss_stall)
        else $error("stall not nine cycles");
    property p_miss_start;
        rs_valid && rs.mispred |=> stall;
    endproperty
    a_miss_start: assert property (p_miss_start)
        else $error("stall missing after mispredict");
    property p_tar_taken;
        lk_valid && l_tarhit && !l_lend && !lk.is_ret
        |=> pred.taken && pred.bubbles == 4'h0;
    endproperty
    a_tar_taken: assert property (p_tar_taken)
        else $error("target register hit not zero-bubble taken");
    property p_loop_end;
        lk_valid && l_lend |=> !pred.taken;
    endproperty
    a_loop_end: assert property (p_loop_end)
        else $error("loop end not predicted not taken");
    property p_static_noalloc;
        rs_valid && is_static(rs.whether) && !rs.is_call && !rs.is_ret
        |-> !r_dnew;
    endproperty
    a_static_noalloc: assert property (p_static_noalloc)
        else $error("static hint allocated direction entry");
    property p_clr_quiet;
        rs_valid && rs.clr |-> !r_dnew && !r_dupd && !r_tac;
    endproperty
    a_clr_quiet: assert property (p_clr_quiet)
        else $error("no_allocate branch changed tables");
    property p_slot_only;
        hi_valid && !hi.is_mov && hi.slot != bhp_pkg::BRP_SLOT
        |-> !h_tac && !h_tar;
    endproperty
    a_slot_only: assert property (p_slot_only)
        else $error("predict hint outside third slot acted");
    property p_prefetch;
        l_pf |=> pf_start && pf_line[bhp_pkg::L2_SHIFT-1:0] == '0;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("prefetch not started");
    property p_ret_bub;
        lk_valid && lk.is_ret && l_tk
        |=> pred.bubbles == ($past(l_dhit) ? 4'h1 : 4'h2);
    endproperty
    a_ret_bub: assert property (p_ret_bub)
        else $error("return bubble count wrong");
    sequence s_ac_used;
        lk_valid && l_tk && lk.ip_rel && !lk.is_ret
        && !l_tarhit && !l_tachit;
    endsequence
    // only a pair whose first branch got the fast corrector
    property p_ac_bub;
        s_ac_used ##0 !ac1_busy ##1 s_ac_used
        |=> pred.bubbles == bhp_pkg::AC2_BUBBLES;
    endproperty
    a_ac_bub: assert property (p_ac_bub)
        else $error("second corrector bubbles wrong");
endmodule // bhp_predictor

// ---- bhp_exec_model.sv ----
`timescale 1ns/1ps
// ============================================================
// execute side: resolves the branch just predicted
module bhp_exec_model (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     en,
    input  wire logic                     act,
    input  wire logic [31:0]              act_tgt,
    input  wire bhp_pkg::bhp_lookup_type  lk,
    input  wire bhp_pkg::bhp_pred_type    pred,
    output logic                          rs_valid,
    output bhp_pkg::bhp_resolve_type      rs
);
    // one pulse a branch, so the bench never sees a double resolve
    always_ff @(posedge aclk) begin
        rs_valid   <= aresetn && en && pred.valid;
        rs         <= '0;
        rs.addr    <= lk.addr;
        rs.btype   <= lk.btype;
        rs.slot    <= lk.slot;
        rs.is_call <= lk.is_call;
        rs.is_ret  <= lk.is_ret;
        rs.whether <= lk.whether;
        rs.clr     <= lk.clr;
        rs.taken   <= act;
        rs.mispred <= pred.taken != act;
        rs.target  <= act_tgt;
    end
endmodule // bhp_exec_model

// ---- test_branch_hint_predictor.sv ----
`timescale 1ns/1ps
// ============================================================
// bench top
module test_branch_hint_predictor;
    logic aclk = 0, aresetn = 0, lk_valid = 0, hi_valid = 0, rs_valid;
    bhp_pkg::bhp_lookup_type  lk = '0, l;
    bhp_pkg::bhp_resolve_type rs;
    bhp_pkg::bhp_hint_type    hi = '0;
    bhp_pkg::bhp_pred_type    pred;
    bhp_pkg::bhp_whether_type w [3] = '{bhp_pkg::W_SPNT,
        bhp_pkg::W_DPNT, bhp_pkg::W_DPNT};
    logic [63:0] lc = 64'h5;
    logic [5:0]  ec = 6'h0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, d, a, t, pf_line;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, r;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pf_start, stall;
    logic en = 0, act = 0;
    int   mismatches = 0, checked = 0, n;
    always #25 aclk = ~aclk;
    bhp_predictor bhp_predictor_inst (.aclk, .aresetn, .lk_valid, .lk,
        .loop_count(lc), .epilog_count(ec), .rs_valid, .rs, .hi_valid,
        .hi, .pred, .pf_start, .pf_line, .stall, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);
    bhp_exec_model bhp_exec_model_inst (.aclk, .aresetn, .en, .act,
        .act_tgt(t), .lk, .pred, .rs_valid, .rs);
    // ============================================================
    // tasks
    task automatic chk(logic [63:0] s, logic [63:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // pred stands one cycle: sampled just after the taking edge
    task automatic look();
        @(posedge aclk);
        lk <= l;
        lk_valid <= 1;
        @(posedge aclk);
        lk_valid <= 0;
        #1;
    endtask
    task automatic hint(logic [1:0] s, logic ind);
        @(posedge aclk);
        hi <= '{1'b0, a, t, s, bhp_pkg::W_LOOP, 1'b1, ind};
        hi_valid <= 1;
        @(posedge aclk);
        hi_valid <= 0;
    endtask
    // handshakes judged at negedge, so no race with the design's edge
    task automatic axi(logic wr, logic [7:0] ad, logic [31:0] wd);
        logic ah, wh, ar, done;
        @(posedge aclk);
        awaddr <= ad;
        araddr <= ad;
        wdata <= wd;
        awvalid <= wr;
        wvalid <= wr;
        arvalid <= !wr;
        bready <= 1;
        rready <= 1;
        for (int i = 0; i < 40; i++) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            ar = arvalid && arready;
            done = (bvalid && bready) || (rvalid && rready);
            d = rdata;
            r = wr ? bresp : rresp;
            @(posedge aclk);
            if (ah) awvalid <= 0;
            if (wh) wvalid <= 0;
            if (ar) arvalid <= 0;
            if (done) begin
                bready <= 0;
                rready <= 0;
                return;
            end
        end
        mismatches++;
        conclude();
    endtask
    // ============================================================
    // sequence
    initial begin
        void'($urandom(32'h3E3D1EFD));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        #1;
        chk({pred, stall, awready, arready}, 42'h3);
        axi(0, bhp_pkg::CTRL_OFS, 0);
        chk(d, bhp_pkg::CTRL_RST);
        axi(0, 8'h0C, 0);
        chk({r, d}, {bhp_pkg::RESP_DECERR, 32'h0});
        $display("registers done");
        for (int k = 0; k < 3; k++) begin
            l = '0;
            l.addr = ($urandom & 32'hFFFF_FF00) | k;
            l.whether = w[k];
            l.clr = k == 2;
            t = $urandom;
            @(posedge aclk);
            en <= 1;
            act <= 1;
            look();
            chk(pred.taken, 0);
            @(posedge aclk);
            en <= 0;
            n = 0;
            repeat (14) begin
                @(posedge aclk);
                #1 n += stall;
            end
            chk(n, 9);
            look();
            chk({pred.taken, pred.bubbles}, k == 1 ? 5'h11 : 5'h0);
        end
        axi(0, bhp_pkg::MISS_OFS, 0);
        chk(d, 3);
        axi(1, bhp_pkg::MISS_OFS, 0);
        chk(r, bhp_pkg::RESP_OKAY);
        axi(0, bhp_pkg::MISS_OFS, 0);
        chk({r, d}, 0);
        $display("direction done");
        for (int k = 0; k < 3; k++) begin
            a = ($urandom & 32'hFFFF_FF00) | (k + 8);
            t = $urandom;
            hint(k == 1 ? 2'h0 : 2'h2, k == 2);
            l = '0;
            l.addr = a;
            l.whether = bhp_pkg::W_SPNT;
            look();
            chk(pred.taken, k == 0);
            if (k == 0) begin
                chk({pred.target, pred.bubbles}, {t, 4'h0});
                ec <= 1;
                lc <= 0;
                look();
                chk(pred.taken, 0);
                ec <= 0;
                lc <= 5;
            end
        end
        $display("hints done");
        l = '0;
        l.addr = ($urandom & 32'hFFFF_FF00) | 8'h20;
        l.disp = $urandom & 32'hFFFF;
        l.ip_rel = 1;
        l.whether = bhp_pkg::W_SPTK;
        l.many = 1;
        l.slot = 2'h2;
        look();
        t = l.addr + l.disp;
        chk({pred.valid, pred.known, pred.taken, pred.target, pred.bubbles},
            {3'h7, t, 4'h2});
        chk({pf_start, pf_line}, {1'b1, ((t >> 3) + 1) << 3});
        $display("corrector done");
        l = '0;
        l.addr = ($urandom & 32'hFFFF_FF00) | 8'h30;
        l.is_call = 1;
        l.clr = 1;
        l.whether = bhp_pkg::W_SPTK;
        a = l.addr + bhp_pkg::NEXT_BUNDLE;
        @(posedge aclk);
        en <= 1;
        look();
        chk(pred.taken, 1);
        @(posedge aclk);
        en <= 0;
        l.addr[1:0] = 2'h3;
        l.is_call = 0;
        l.is_ret = 1;
        look();
        chk({pred.target, pred.bubbles}, {a, 4'h2});
        $display("stack done");
        conclude();
    end
endmodule // test_branch_hint_predictor
